// [plm_array.sv]
// Decode array, general logic array and 16 output cells with host load/read.
// Assumes all pins and host strobes are synchronous to clk; the term plane
// (which inputs feed each product term) is held in configuration inputs.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Turbo off: standby after 70 ns idle
// - Five bits gate host controls off bus
// - One shared 82-signal input bus
// - Separate-space mode takes A19-A4 as address
// - Decode array makes sector, sram, config selects
// - Eight chip selects, one term, no cells
// - AND plane forms up to 196 terms
// - Group A on D0-D7, B on D8-D15; lanes swap when big-endian
// - Native and borrowed term counts per cell
// - Used terms not shared with other cells
// - XOR polarity, register/combinatorial mux, feedback
// - Storage configurable as D, T, JK, SR
// - Clock from product term or external pin
// - Preset, clear active high; clear two terms
// - Host load overrides preset, clear, clock
// - Host data captured at strobe trailing edge
// - Per-group write-block masks reset to 00h
// - Host reads input and output cells
// - Pin enable is term OR direction bit
// - No enable equation: driver on from first clock after reset
// - Internal node still feeds back, pin free
module plm_array
#(
    parameter int pt_total = plm_pkg::pt_count
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [19:0] host_addr,
    input wire logic [2:0] host_control_inputs,
    input wire logic host_write_strobe,
    input wire logic power_down_input,
    input wire logic logic_reset,
    input wire logic [15:0] host_wdata,
    input wire logic host_big_endian,
    input wire logic separate_space_mode,
    input wire logic omc_sel,
    input wire logic mask_a_sel,
    input wire logic mask_b_sel,
    input wire logic [23:0] input_cell_q,
    input wire logic [3:0] port_d_in,
    input wire logic [7:0] port_f_in,
    input wire logic [7:0] page_bits,
    input wire logic flash_ready,
    input wire logic external_logic_clock,
    input wire logic turbo_on,
    input wire logic [4:0] control_gating_reg,
    input wire logic [plm_pkg::pt_count-1:0][plm_pkg::input_bus_width-1:0] pt_true,
    input wire logic [plm_pkg::pt_count-1:0][plm_pkg::input_bus_width-1:0] pt_comp,
    input wire logic [plm_pkg::cell_count-1:0][plm_pkg::pt_per_cell-1:0] cell_pt_map,
    input wire logic [plm_pkg::cell_count-1:0][7:0] cell_pt_base,
    input wire logic [plm_pkg::cell_count-1:0] cell_invert,
    input wire plm_pkg::plm_ff_kind_t [plm_pkg::cell_count-1:0] cell_kind,
    input wire logic [plm_pkg::cell_count-1:0] cell_use_reg,
    input wire logic [plm_pkg::cell_count-1:0] cell_ext_clk,
    input wire logic [plm_pkg::cell_count-1:0] cell_internal_node,
    input wire logic [plm_pkg::cell_count-1:0] cell_has_oe_eq,
    input wire logic [plm_pkg::cell_count-1:0] direction_bits,
    input wire logic [plm_pkg::ecs_count-1:0] ecs_invert,
    output logic [plm_pkg::cell_count-1:0] port_ab_out,
    output logic [plm_pkg::cell_count-1:0] port_ab_oe,
    output logic [plm_pkg::ecs_count-1:0] external_chip_selects,
    output logic [7:0] primary_sector_selects,
    output logic [3:0] secondary_sector_selects,
    output logic sram_select,
    output logic config_space_select,
    output logic test_port_enable,
    output logic [1:0] peripheral_selects,
    output logic [15:0] host_rdata,
    output logic [39:0] cell_readback,
    output logic [7:0] group_a_write_block_mask,
    output logic [7:0] group_b_write_block_mask,
    output logic arrays_standby
);
    import plm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Shared input bus.
    logic [input_bus_width-1:0] in_bus;
    logic [input_bus_width-1:0] prev_bus;
    logic [15:0] arr_addr;
    logic [2:0] ctl_gated;
    logic [1:0] misc_gated;
    logic [15:0] fb;
    logic [pt_count-1:0] pt;

    assign arr_addr = separate_space_mode ? host_addr[19:4] : host_addr[15:0];
    // Gated controls read as zero so they never toggle the plane.
    assign ctl_gated = host_control_inputs & ~control_gating_reg[2:0];
    assign misc_gated = {power_down_input, logic_reset} & ~control_gating_reg[4:3];
    assign in_bus = {flash_ready, fb, page_bits, port_f_in, port_d_in, input_cell_q,
                     misc_gated, ctl_gated, arr_addr};

    ////////////////////////////////////////////////////////////////////////
    // AND plane.
    function automatic logic term_eval(input logic [input_bus_width-1:0] bus,
                                       input logic [input_bus_width-1:0] t,
                                       input logic [input_bus_width-1:0] c);
        term_eval = &(~t | bus) & &(~c | ~bus);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < pt_total; gi++)
        begin : g_pt
            assign pt[gi] = term_eval(in_bus, pt_true[gi], pt_comp[gi]);
        end
        for (gi = pt_total; gi < pt_count; gi++)
        begin : g_pt_off
            assign pt[gi] = 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Standby detection.
    logic [3:0] idle_cnt;
    plm_pwr_t pwr_state;
    always_ff @(posedge clk)
    begin
        if (rst)
            prev_bus <= '0;
        else
            prev_bus <= in_bus;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            idle_cnt <= 4'h0;
            pwr_state <= pwr_active;
        end
        else if (turbo_on || in_bus != prev_bus)
        begin
            idle_cnt <= 4'h0;
            pwr_state <= pwr_active;
        end
        else if (idle_cnt < 4'(standby_idle_cycles - 1))
            idle_cnt <= idle_cnt + 4'h1;
        else
            pwr_state <= pwr_standby;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            arrays_standby <= 1'b0;
        else
            arrays_standby <= (pwr_state == pwr_standby);
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode array: terms 0..38 are select terms, 39..42 single ones.
    logic [sel_count-1:0] sel_or;
    generate
        for (gi = 0; gi < sel_count; gi++)
        begin : g_sel
            assign sel_or[gi] = |pt[gi*sel_pt +: sel_pt];
        end
    endgenerate
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            primary_sector_selects <= 8'h00;
            secondary_sector_selects <= 4'h0;
            sram_select <= 1'b0;
            config_space_select <= 1'b0;
            test_port_enable <= 1'b0;
            peripheral_selects <= 2'h0;
        end
        else
        begin
            primary_sector_selects <= sel_or[7:0];
            secondary_sector_selects <= sel_or[11:8];
            sram_select <= sel_or[12];
            config_space_select <= pt[39];
            test_port_enable <= pt[40];
            peripheral_selects <= pt[42:41];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External chip selects: one term each, no output cell used.
    always_ff @(posedge clk)
    begin
        if (rst)
            external_chip_selects <= 8'h00;
        else
            external_chip_selects <= pt[50:43] ^ ecs_invert;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-block masks and host load.
    logic strobe_d;
    logic strobe_trail;
    logic [15:0] lane_data;
    logic [15:0] cell_mask;
    always_ff @(posedge clk)
    begin
        if (rst)
            strobe_d <= 1'b0;
        else
            strobe_d <= host_write_strobe;
    end
    assign strobe_trail = strobe_d & ~host_write_strobe;
    assign lane_data = host_big_endian ? {host_wdata[7:0], host_wdata[15:8]} : host_wdata;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            group_a_write_block_mask <= mask_reset;
            group_b_write_block_mask <= mask_reset;
        end
        else if (strobe_trail)
        begin
            if (mask_a_sel)
                group_a_write_block_mask <= lane_data[7:0];
            if (mask_b_sel)
                group_b_write_block_mask <= lane_data[15:8];
        end
    end
    assign cell_mask = {group_b_write_block_mask, group_a_write_block_mask};

    ////////////////////////////////////////////////////////////////////////
    // Output cells with term allocation.
    logic [15:0] cell_out;
    always_ff @(posedge clk)
    begin
        if (rst)
            fb <= 16'h0000;
        else
            fb <= cell_out;
    end

    function automatic int native_of(input int n);
        native_of = (n < cells_per_group) ? a_native : b_lo_native;
    endfunction
    function automatic int limit_of(input int n);
        if (n < cells_per_group)
            limit_of = a_native + a_borrow;
        else if (n < 12)
            limit_of = b_lo_native + b_lo_borrow;
        else
            limit_of = b_hi_native + b_hi_borrow;
    endfunction

    // Borrowed terms come from a pool above the select terms; a term claimed
    // by a lower-numbered cell is withheld from higher ones.
    logic [15:0][pt_count-1:0] claim;
    generate
        for (gi = 0; gi < cell_count; gi++)
        begin : g_cell
            logic [pt_count-1:0] mine;
            logic [pt_count-1:0] taken;
            logic sum_main;
            logic pt_clk;
            logic pt_clk_d;
            logic ext_d;
            logic clk_ev;
            logic preset;
            logic clear;
            always_comb
            begin
                mine = '0;
                for (int k = 0; k < pt_per_cell; k++)
                begin
                    if (k < limit_of(gi) && cell_pt_map[gi][k])
                        mine[(int'(cell_pt_base[gi]) + k) % pt_count] = 1'b1;
                end
            end
            if (gi == 0)
            begin : g_first
                assign taken = '0;
            end
            else
            begin : g_next
                assign taken = claim[gi-1];
            end
            assign claim[gi] = taken | mine;
            assign sum_main = |(pt & mine & ~taken);
            assign pt_clk = pt[60 + gi];
            assign preset = pt[100 + gi];
            assign clear = pt[120 + gi] | pt[140 + gi];
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    pt_clk_d <= 1'b0;
                    ext_d <= 1'b0;
                end
                else
                begin
                    pt_clk_d <= pt_clk;
                    ext_d <= external_logic_clock;
                end
            end
            assign clk_ev = cell_ext_clk[gi] ? (external_logic_clock & ~ext_d)
                                             : (pt_clk & ~pt_clk_d);
            plm_output_cell u_cell
            (
                .clk(clk),
                .rst(rst),
                .sum_main(sum_main),
                .sum_aux(pt[80 + gi]),
                .invert(cell_invert[gi]),
                .kind(cell_kind[gi]),
                .use_reg(cell_use_reg[gi]),
                .clk_event(clk_ev),
                .preset(preset),
                .clear(clear),
                .host_load(strobe_trail & omc_sel & ~cell_mask[gi]),
                .host_data(lane_data[gi]),
                .cell_out(cell_out[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pins and readback.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            port_ab_out <= 16'h0000;
            port_ab_oe <= 16'h0000;
        end
        else
        begin
            port_ab_out <= cell_out;
            for (int n = 0; n < cell_count; n++)
            begin
                if (cell_internal_node[n])
                    port_ab_oe[n] <= direction_bits[n];
                else if (!cell_has_oe_eq[n])
                    port_ab_oe[n] <= 1'b1;
                else
                    port_ab_oe[n] <= pt[170 + n] | direction_bits[n];
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            host_rdata <= 16'h0000;
            cell_readback <= 40'h0;
        end
        else
        begin
            host_rdata <= host_big_endian ? {cell_out[7:0], cell_out[15:8]} : cell_out;
            cell_readback <= {input_cell_q, cell_out};
        end
    end
endmodule
`default_nettype wire

// [plm_pkg.sv]
// Constants shared by the programmable logic macrocell array.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package plm_pkg;
    localparam int clk_period_ns = 10;
    localparam int standby_idle_ns = 70;
    localparam int standby_idle_cycles = standby_idle_ns / clk_period_ns;
    localparam int input_bus_width = 82;
    localparam int pt_count = 196;
    localparam int cells_per_group = 8;
    localparam int cell_count = 16;
    localparam int ecs_count = 8;
    localparam int gate_bits = 5;
    localparam int turbo_bit = 3;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam int a_native = 3;
    localparam int a_borrow = 6;
    localparam int b_lo_native = 4;
    localparam int b_lo_borrow = 5;
    localparam int b_hi_native = 4;
    localparam int b_hi_borrow = 6;
    localparam int pt_per_cell = 10;
    localparam int sel_pt = 3;
    localparam int sel_count = 13;
    typedef enum logic [1:0] {ff_d, ff_t, ff_jk, ff_sr} plm_ff_kind_t;
    typedef enum logic [1:0] {pwr_active, pwr_standby} plm_pwr_t;
endpackage

// [plm_output_cell.sv]
// One output macrocell: term sum, polarity, D/T/JK/SR storage and host load.
// Assumes product terms and strobe events are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module plm_output_cell
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sum_main,
    input wire logic sum_aux,
    input wire logic invert,
    input wire plm_pkg::plm_ff_kind_t kind,
    input wire logic use_reg,
    input wire logic clk_event,
    input wire logic preset,
    input wire logic clear,
    input wire logic host_load,
    input wire logic host_data,
    output logic cell_out
);
    import plm_pkg::*;
    logic q;
    logic d_in;
    logic next_q;
    assign d_in = sum_main ^ invert;
    always_comb
    begin
        unique case (kind)
            ff_d: next_q = d_in;
            ff_t: next_q = q ^ d_in;
            ff_jk: next_q = (d_in & ~q) | (~sum_aux & q);
            ff_sr: next_q = d_in | (q & ~sum_aux);
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= 1'b0;
        else if (host_load)
            q <= host_data;
        else if (clear)
            q <= 1'b0;
        else if (preset)
            q <= 1'b1;
        else if (clk_event)
            q <= next_q;
    end
    assign cell_out = use_reg ? q : d_in;
endmodule
`default_nettype wire

// [plm_array_monitor.sv]
// Checker for the macrocell array top: standby, masks, pin enables, host loads.
// Assumes it is bound to plm_array and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module plm_array_monitor
#(
    parameter int pt_total = plm_pkg::pt_count
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [19:0] host_addr,
    input wire logic host_write_strobe,
    input wire logic [15:0] host_wdata,
    input wire logic host_big_endian,
    input wire logic omc_sel,
    input wire logic mask_a_sel,
    input wire logic [23:0] input_cell_q,
    input wire logic [7:0] page_bits,
    input wire logic turbo_on,
    input wire logic [15:0] cell_use_reg,
    input wire logic [15:0] cell_has_oe_eq,
    input wire logic [15:0] cell_internal_node,
    input wire logic [15:0] direction_bits,
    input wire logic [15:0] port_ab_out,
    input wire logic [15:0] port_ab_oe,
    input wire logic [39:0] cell_readback,
    input wire logic [7:0] group_a_write_block_mask,
    input wire logic [7:0] group_b_write_block_mask,
    input wire logic arrays_standby
);
    import plm_pkg::*;
    ////////////////////////////////////////
    // Counts cycles with quiet inputs and turbo off.
    logic [4:0] idle;
    always_ff @(posedge clk)
    begin
        if (rst || turbo_on
            || !$stable({host_addr, host_write_strobe, input_cell_q, page_bits, port_ab_out}))
            idle <= 5'h00;
        else if (idle != 5'h1f)
            idle <= idle + 5'h01;
    end
    ////////////////////////////////////////
    a_standby_after_idle: assert property (@(posedge clk) disable iff (rst)
        idle >= standby_idle_cycles + 3 |-> arrays_standby)
        else $error("no standby after idle inputs");
    a_turbo_keeps_awake: assert property (@(posedge clk) disable iff (rst)
        turbo_on [*3] |-> !arrays_standby)
        else $error("standby while turbo on");
    a_input_wakes: assert property (@(posedge clk) disable iff (rst)
        $changed(page_bits) |-> ##[0:2] !arrays_standby)
        else $error("standby held after input change");
    a_masks_cleared: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> group_a_write_block_mask == 8'h00 && group_b_write_block_mask == 8'h00)
        else $error("mask not cleared by reset");
    a_mask_a_load: assert property (@(posedge clk) disable iff (rst)
        $fell(host_write_strobe) && mask_a_sel && !host_big_endian
        |=> group_a_write_block_mask == $past(host_wdata[7:0]))
        else $error("mask write lost");
    a_default_enable: assert property (@(posedge clk) disable iff (rst)
        !rst |=> (port_ab_oe | $past(cell_has_oe_eq) | $past(cell_internal_node)) == 16'hffff)
        else $error("pin driver off without enable equation");
    a_direction_enable: assert property (@(posedge clk) disable iff (rst)
        !rst |=> (port_ab_oe | ~$past(direction_bits) | $past(cell_internal_node)) == 16'hffff)
        else $error("direction bit did not enable pin");
    a_low_lane_load: assert property (@(posedge clk) disable iff (rst)
        $fell(host_write_strobe) && omc_sel && !host_big_endian
        && group_a_write_block_mask == 8'h00 && cell_use_reg[7:0] == 8'hff
        |-> ##[1:2] cell_readback[7:0] == $past(host_wdata[7:0]))
        else $error("low lane load missing");
    a_high_lane_swap: assert property (@(posedge clk) disable iff (rst)
        $fell(host_write_strobe) && omc_sel && host_big_endian
        && group_b_write_block_mask == 8'h00 && cell_use_reg[15:8] == 8'hff
        |-> ##[1:2] cell_readback[15:8] == $past(host_wdata[7:0]))
        else $error("swapped lane load missing");
endmodule
bind plm_array plm_array_monitor #(.pt_total(pt_total)) u_plm_array_monitor (
    .clk, .rst, .host_addr, .host_write_strobe, .host_wdata, .host_big_endian, .omc_sel,
    .mask_a_sel, .input_cell_q, .page_bits, .turbo_on, .cell_use_reg, .cell_has_oe_eq,
    .cell_internal_node, .direction_bits, .port_ab_out, .port_ab_oe, .cell_readback,
    .group_a_write_block_mask, .group_b_write_block_mask, .arrays_standby);
`default_nettype wire

// [plm_host_model.sv]
// Host processor model: level write strobe with target selects and data.
// Assumes the array takes a write at the clock edge after the strobe falls.
`timescale 1ns/1ns
`default_nettype none
module plm_host_model
(
    input wire logic clk,
    output logic [19:0] host_addr,
    output logic host_write_strobe,
    output logic [15:0] host_wdata,
    output logic omc_sel,
    output logic mask_a_sel,
    output logic mask_b_sel
);
    initial
    begin
        {host_addr, host_write_strobe, host_wdata, omc_sel, mask_a_sel, mask_b_sel} = '0;
    end
    task automatic set_addr(input logic [19:0] a);
        host_addr = a;
    endtask
    // Holds selects and data until two edges after the taken edge, then
    // scrambles the data so a stale bus value is never mistaken for a load.
    task automatic write(input logic [2:0] tgt, input logic [15:0] d, input int slow);
        @(posedge clk);
        #1;
        {mask_b_sel, mask_a_sel, omc_sel} = tgt;
        host_wdata = d;
        host_write_strobe = 1'b1;
        repeat (slow + 1) @(posedge clk);
        #1;
        host_write_strobe = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        {mask_b_sel, mask_a_sel, omc_sel} = 3'h0;
        host_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [plm_array_bench.sv]
// Self-checking bench for the macrocell array: loads, masks, enables, standby.
// Assumes every product term but 39 and 43 is held false, so cells change only by host or clock pin.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module plm_array_bench;
    import plm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] host_control_inputs;
    logic power_down_input, logic_reset, host_big_endian, separate_space_mode;
    logic flash_ready, external_logic_clock, turbo_on, host_write_strobe;
    logic omc_sel, mask_a_sel, mask_b_sel, sram_select, config_space_select;
    logic test_port_enable, arrays_standby;
    logic [19:0] host_addr;
    logic [15:0] host_wdata, port_ab_out, port_ab_oe, host_rdata, cells, masks, d;
    logic [23:0] input_cell_q;
    logic [3:0] port_d_in, secondary_sector_selects;
    logic [7:0] port_f_in, page_bits, ecs_invert, external_chip_selects;
    logic [7:0] primary_sector_selects, group_a_write_block_mask, group_b_write_block_mask;
    logic [4:0] control_gating_reg;
    logic [pt_count-1:0][input_bus_width-1:0] pt_true, pt_comp;
    logic [15:0][9:0] cell_pt_map;
    logic [15:0][7:0] cell_pt_base;
    logic [15:0] cell_invert, cell_use_reg, cell_ext_clk, cell_internal_node;
    logic [15:0] cell_has_oe_eq, direction_bits;
    plm_ff_kind_t [15:0] cell_kind;
    logic [1:0] peripheral_selects;
    logic [39:0] cell_readback;
    logic [31:0] seed = 32'hf39dc540;
    logic [31:0] r;
    int fail_count = 0;
    int n_checks = 0;
    int it, n;
    ////////////////////////////////////////
    always #5 clk = ~clk;
    plm_host_model u_plm_host_model (.clk, .host_addr, .host_write_strobe, .host_wdata,
        .omc_sel, .mask_a_sel, .mask_b_sel);
    plm_array u_plm_array (.clk, .rst, .host_addr, .host_control_inputs, .host_write_strobe,
        .power_down_input, .logic_reset, .host_wdata, .host_big_endian, .separate_space_mode,
        .omc_sel, .mask_a_sel, .mask_b_sel, .input_cell_q, .port_d_in, .port_f_in, .page_bits,
        .flash_ready, .external_logic_clock, .turbo_on, .control_gating_reg, .pt_true,
        .pt_comp, .cell_pt_map, .cell_pt_base, .cell_invert, .cell_kind, .cell_use_reg,
        .cell_ext_clk, .cell_internal_node, .cell_has_oe_eq, .direction_bits, .ecs_invert,
        .port_ab_out, .port_ab_oe, .external_chip_selects, .primary_sector_selects,
        .secondary_sector_selects, .sram_select, .config_space_select, .test_port_enable,
        .peripheral_selects, .host_rdata, .cell_readback, .group_a_write_block_mask,
        .group_b_write_block_mask, .arrays_standby);
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], ^(seed & 32'h80200003)};
        return seed;
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_all();
        `CHK("mask_a", masks[7:0], group_a_write_block_mask)
        `CHK("mask_b", masks[15:8], group_b_write_block_mask)
        `CHK("port_out", (cells & cell_use_reg) | (cell_invert & ~cell_use_reg), port_ab_out)
        `CHK("pin_oe", (~cell_has_oe_eq | direction_bits) & ~cell_internal_node,
            port_ab_oe & ~cell_internal_node)
        `CHK("chip_sel", ecs_invert, external_chip_selects)
        `CHK("selects", 17'h00000, {primary_sector_selects, secondary_sector_selects,
            sram_select, config_space_select, test_port_enable, peripheral_selects})
        `CHK("in_cells", input_cell_q, cell_readback[39:16])
        if (cell_use_reg == 16'hffff)
        begin
            `CHK("out_cells", cells, cell_readback[15:0])
            `CHK("rdata", host_big_endian ? {cells[7:0], cells[15:8]} : cells, host_rdata)
        end
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        test_done();
    end
    initial
    begin
        {host_control_inputs, power_down_input, logic_reset, host_big_endian} = '0;
        {separate_space_mode, flash_ready, external_logic_clock, input_cell_q} = '0;
        {port_d_in, port_f_in, page_bits, ecs_invert, control_gating_reg} = '0;
        {cell_invert, cell_use_reg, cell_ext_clk, cell_internal_node} = '0;
        {cell_has_oe_eq, direction_bits, cells, masks, cell_pt_map, cell_pt_base} = '0;
        turbo_on = 1'b1;
        pt_true = {pt_count{82'h1}};
        pt_comp = {pt_count{82'h1}};
        for (n = 0; n < 16; n++)
            cell_kind[n] = ff_d;
        step(12);
        rst = 1'b0;
        step(2);
        cmp_all();
        for (it = 0; it < 16; it++)
        begin
            r = rnd();
            {cell_invert, cell_has_oe_eq} = r;
            r = rnd();
            direction_bits = r[15:0];
            cell_internal_node = r[31:16] & r[23:8];
            ecs_invert = r[7:0];
            cell_use_reg = (it % 4 < 2) ? 16'hffff : r[31:16];
            host_big_endian = it[0];
            r = rnd();
            {input_cell_q, page_bits} = r;
            r = rnd();
            {port_d_in, port_f_in, host_control_inputs, power_down_input, logic_reset,
                flash_ready, control_gating_reg, separate_space_mode} = r[23:0];
            u_plm_host_model.set_addr(r[31:12]);
            if (it % 3 != 0)
            begin
                masks = (it % 3 == 1) ? r[15:0] : 16'h0000;
                u_plm_host_model.write(3'h2, {2{masks[7:0]}}, 0);
                u_plm_host_model.write(3'h4, {2{masks[15:8]}}, 1);
            end
            r = rnd();
            d = r[15:0];
            u_plm_host_model.write(3'h1, d, it % 2 * 2);
            for (n = 0; n < 16; n++)
                if (!masks[n])
                    cells[n] = d[host_big_endian ? n ^ 8 : n];
            step(3);
            cmp_all();
        end
        // A reset in mid-run must clear masks and cells written above.
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        {cells, masks} = '0;
        step(2);
        cmp_all();
        cell_ext_clk = 16'hffff;
        cell_use_reg = 16'hffff;
        for (it = 0; it < 2; it++)
        begin
            r = rnd();
            for (n = 0; n < 16; n++)
                cell_kind[n] = plm_ff_kind_t'(r[2 * n +: 2]);
            step(1);
            external_logic_clock = 1'b1;
            step(2);
            external_logic_clock = 1'b0;
            // With every term false, K and R stay low, so JK and SR cells only set or hold.
            for (n = 0; n < 16; n++)
                if (cell_kind[n] == ff_d)
                    cells[n] = cell_invert[n];
                else if (cell_kind[n] == ff_t)
                    cells[n] = cells[n] ^ cell_invert[n];
                else
                    cells[n] = cells[n] | cell_invert[n];
            step(3);
            cmp_all();
        end
        cell_ext_clk = 16'h0000;
        turbo_on = 1'b0;
        step(14);
        `CHK("standby", 1'b1, arrays_standby)
        page_bits = ~page_bits;
        step(3);
        `CHK("wake", 1'b0, arrays_standby)
        turbo_on = 1'b1;
        step(14);
        `CHK("turbo", 1'b0, arrays_standby)
        // Term 43 needs plane address bit 0, term 39 needs host control 0.
        pt_comp[43] = '0;
        pt_comp[39] = '0;
        pt_true[39] = 82'h1 << 16;
        {host_control_inputs, control_gating_reg, separate_space_mode} = 9'h041;
        u_plm_host_model.set_addr(20'h00010);
        step(2);
        `CHK("ecs_addr", ecs_invert ^ 8'h01, external_chip_selects)
        `CHK("cfg_sel", 1'b1, config_space_select)
        {control_gating_reg, separate_space_mode} = 6'h02;
        step(2);
        `CHK("ecs_addr", ecs_invert, external_chip_selects)
        `CHK("cfg_sel", 1'b0, config_space_select)
        test_done();
    end
endmodule
`default_nettype wire
